// ==== design/serial_rx.sv ====
// Receive status flags, data buffer and bit rate generator of an async serial port.
// Assumes a single core clock, an asynchronous serial input pin and a one-cycle
// strobe register port with read data one cycle after the read strobe.
//
// What this block does
// (R1) Overrun set when buffer still full
// (R2) Overrun discards new character, keeps old
// (R3) Overrun with enable raises error request
// (R4) Overrun cleared by status-then-data read sequence
// (R5) Noise flag, enable, status-then-data clear
// (R6) Zero stop bit sets framing flag
// (R7) Parity failure sets parity flag
// (R8) Framing, parity cleared by status-then-data reads
// (R9) Reset clears all four error flags
// (R10) Status two: break, active; rest zero
// (R11) Break sets break, framing, full; ninth cleared
// (R12) Break no interrupt; status-two-then-data clear
// (R13) Break re-arms only after ones seen
// (R14) Active flag set on first low sample
// (R15) Active cleared on false start or idle
// (R16) Data address: read received, write transmit
// (R17) One rate drives receiver and transmitter
// (R18) Prescale codes give 1, 3, 4, 13
// (R19) Rate field divides by power of two
// (R20) Bit rate is clock over 64*PD*BD
// (R21) Software rereads status one to spot loss
// (R22) Error request is OR of enabled flags
`timescale 1ns/1ps
`default_nettype none

module serial_rx
  import serial_rx_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              rstn,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wr_data,
  input  wire logic              wr_en,
  input  wire logic              rd_en,
  output logic      [DATA_W-1:0] rd_data,
  input  wire logic              serial_input_pin,
  output logic                   serial_error_irq,
  output logic      [DATA_W-1:0] tx_data,
  output logic                   tx_ninth,
  output logic                   tx_write,
  output logic                   baud_tick
);

  // ********************************************************
  // Helpers
  // ********************************************************
  // Last divider count (clocks per receiver sample minus one) for a prescale code and a rate code
  function automatic logic [RT_CNT_W-1:0] rt_period(input logic [1:0] pre,
                                                     input logic [2:0] rdiv);
    int pd;
    pd = 1;
    unique case (pre)
      2'h0: pd = 1;
      2'h1: pd = 3;
      2'h2: pd = 4;
      2'h3: pd = 13;
    endcase
    return RT_CNT_W'(((CLK_PER_RT * pd) << rdiv) - 1);
  endfunction

  function automatic logic maj3(input logic [2:0] s);
    return (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
  endfunction

  // ********************************************************
  // Registers and state
  // ********************************************************
  logic                rx_sync1;
  logic                rx_sync2;
  logic [1:0]          prescale_field;
  logic [2:0]          rate_divider_field;
  logic [3:0]          format;
  logic [4:0]          ctrl3;
  logic [RT_CNT_W-1:0] rt_div;
  logic                rt_tick;
  logic [3:0]          bit_div;
  rx_state_e           state;
  logic [3:0]          phase;
  logic [1:0]          samples;
  logic [3:0]          bit_idx;
  logic [8:0]          shift;
  logic                char_noise;
  logic                prev_high;
  logic [7:0]          high_run;
  logic                char_done;
  rx_char_s            rx_char;
  logic                rx_full_flag;
  logic                idle_flag;
  logic                overrun_flag;
  logic                noise_flag;
  logic                framing_fault_flag;
  logic                parity_fault_flag;
  logic                break_seen_flag;
  logic                rx_active_flag;
  logic                rx_ninth_bit;
  logic                break_armed;
  logic                idle_ok;
  logic [5:0]          arm1;
  logic                arm_brk;
  logic [7:0]          serial_data_buffer;

  // ********************************************************
  // Bus decode
  // ********************************************************
  wire        sel_ctrl3  = addr == CTRL3_ADDR;
  wire        sel_stat1  = addr == STAT1_ADDR;
  wire        sel_stat2  = addr == STAT2_ADDR;
  wire        sel_data   = addr == DATA_ADDR;
  wire        sel_rate   = addr == RATE_ADDR;
  wire        sel_format = addr == FORMAT_ADDR;
  wire        rd_stat1   = rd_en && sel_stat1;
  wire        rd_stat2   = rd_en && sel_stat2;
  wire        rd_buf     = rd_en && sel_data;
  wire        wr_buf     = wr_en && sel_data;

  wire [7:0] rx_status_one = {2'h0, rx_full_flag, idle_flag, overrun_flag,
                              noise_flag, framing_fault_flag, parity_fault_flag};
  // Upper bits are hard zeros, and nothing writes this register [R10]
  wire [7:0] rx_status_two = {6'h00, break_seen_flag, rx_active_flag};
  wire [7:0] serial_control_three = {rx_ninth_bit, tx_ninth, 2'h0, ctrl3[3:0]};
  wire [7:0] bit_rate_select = {2'h0, prescale_field, 1'b0, rate_divider_field};

  wire [7:0] rd_mux = sel_ctrl3  ? serial_control_three :
                      sel_stat1  ? rx_status_one :
                      sel_stat2  ? rx_status_two :
                      sel_data   ? serial_data_buffer :  // [R16]
                      sel_rate   ? bit_rate_select :
                      sel_format ? {4'h0, format} : 8'h00;

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      rd_data <= 8'h00;
    else
      rd_data <= rd_en ? rd_mux : 8'h00;
  end

  // Software controlled configuration
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      prescale_field     <= PRESCALE_RST;  // [R18]
      rate_divider_field <= RATE_DIV_RST;  // [R19]
      format             <= FORMAT_RST;
      ctrl3              <= CTRL3_RST;
      tx_ninth           <= 1'b0;
    end
    else if (wr_en)
    begin
      if (sel_rate)
      begin
        prescale_field     <= wr_data[RATE_PRE_LSB +: 2];
        rate_divider_field <= wr_data[RATE_DIV_LSB +: 3];
      end
      if (sel_format)
        format <= wr_data[3:0];
      if (sel_ctrl3)
      begin
        ctrl3    <= {1'b0, wr_data[3:0]};
        tx_ninth <= wr_data[C3_TX_NINTH];
      end
    end
  end

  // Transmit byte is handed on with a one-cycle load pulse [R16]
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      tx_data  <= 8'h00;
      tx_write <= 1'b0;
    end
    else
    begin
      tx_write <= wr_buf;
      if (wr_buf)
        tx_data <= wr_data;
    end
  end

  // ********************************************************
  // Rate generator
  // ********************************************************
  // One divider feeds the receiver samples and the transmit bit tick [R17]
  wire [RT_CNT_W-1:0] rt_limit = rt_period(prescale_field, rate_divider_field); // [R18] [R19]

  // Sample tick is 16 per bit, so a bit takes 64*PD*BD clocks [R20]
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rt_div    <= '0;
      rt_tick   <= 1'b0;
      bit_div   <= 4'h0;
      baud_tick <= 1'b0;
    end
    else
    begin
      rt_tick   <= rt_div >= rt_limit;
      rt_div    <= (rt_div >= rt_limit) ? '0 : rt_div + 1'b1;  // [R20]
      baud_tick <= rt_tick && bit_div == PHASE_LAST;
      if (rt_tick)
        bit_div <= bit_div + 4'h1;
    end
  end

  // ********************************************************
  // Receive sampler
  // ********************************************************
  // Pin passes two flops before anything reads it
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rx_sync1 <= 1'b1;
      rx_sync2 <= 1'b1;
    end
    else
    begin
      rx_sync1 <= serial_input_pin;
      rx_sync2 <= rx_sync1;
    end
  end

  wire       line      = rx_sync2;
  wire [3:0] phase_n   = phase + 4'h1;
  wire [2:0] votes     = {samples, line};
  wire       vote      = maj3(votes);
  wire       unanimous = votes == 3'h0 || votes == 3'h7;
  wire       in_window = phase_n >= SAMPLE_FIRST && phase_n <= SAMPLE_LAST;
  wire       decide    = phase_n == SAMPLE_LAST;
  wire       bit_end   = phase == PHASE_LAST;
  wire [3:0] nbits     = BITS_EIGHT + {3'h0, format[FMT_NINE]};
  wire       rx_on     = format[FMT_RX_ON];
  wire       start_low = rt_tick && state == st_hunt && !line && prev_high;
  wire       false_st  = rt_tick && state == st_start && decide && vote;
  wire       idle_hit  = rt_tick && state == st_hunt && line && high_run == IDLE_RT - 8'h1;

  rx_state_e next_state;

  // Bit-level sequencing; a start bit needs a preceding high sample
  always_comb
  begin
    next_state = state;
    if (!rx_on)
      next_state = st_hunt;
    else if (rt_tick)
    begin
      unique case (state)
        st_hunt:  if (start_low) next_state = st_start;
        st_start: if (false_st) next_state = st_hunt;
                  else if (bit_end) next_state = st_data;
        st_data:  if (bit_end && bit_idx == nbits - 4'h1) next_state = st_stop;
        st_stop:  if (decide) next_state = st_hunt;
      endcase
    end
  end

  // Character assembly, LSB first, majority of three middle samples
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state      <= st_hunt;
      phase      <= 4'h0;
      samples    <= 2'h3;
      bit_idx    <= 4'h0;
      shift      <= 9'h000;
      char_noise <= 1'b0;
      prev_high  <= 1'b0;
      high_run   <= 8'h00;
    end
    else
    begin
      state <= next_state;
      if (rt_tick)
      begin
        phase <= (state == st_hunt || bit_end) ? 4'h0 : phase_n;
        if (in_window)
          samples <= {samples[0], line};
        if (state == st_hunt)
        begin
          prev_high  <= line;
          char_noise <= 1'b0;
          bit_idx    <= 4'h0;
          high_run   <= (line && high_run != IDLE_RT) ? high_run + 8'h1 : (line ? high_run : 8'h00);
        end
        else
          high_run <= 8'h00;
        if (decide && state != st_hunt && !unanimous)
          char_noise <= 1'b1;  // [R5]
        if (decide && state == st_data)
          shift <= {vote, shift[8:1]};
        if (bit_end && state == st_data)
          bit_idx <= bit_idx + 4'h1;
        if (decide && state == st_stop)
          prev_high <= vote;
      end
    end
  end

  // Completed character, normalised to byte plus ninth bit
  wire       nine     = format[FMT_NINE];
  wire [7:0] got_byte = nine ? shift[7:0] : shift[8:1];
  wire       got_9th  = shift[8];  // Copy of bit 7 in eight-bit mode
  wire       got_par  = nine ? ^shift : ^shift[8:1];
  wire       stop_end = rt_tick && rx_on && state == st_stop && decide;
  wire       is_brk   = !vote && got_byte == 8'h00 && !(nine && got_9th);

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      char_done <= 1'b0;
      rx_char   <= '0;
    end
    else
    begin
      char_done <= stop_end;
      if (stop_end)
      begin
        rx_char.data       <= got_byte;
        rx_char.ninth      <= got_9th;
        rx_char.noise      <= char_noise || !unanimous;
        rx_char.parity_bad <= format[FMT_PAR_ON] && (got_par ^ format[FMT_PAR_ODD]);  // [R7]
        rx_char.framing    <= !vote;  // [R6]
        rx_char.brk        <= is_brk && break_armed;  // [R13]
      end
    end
  end

  // ********************************************************
  // Status flags
  // ********************************************************
  // A data read clears only the flags seen set at the last status read
  wire [5:0] clr1    = rd_buf ? arm1 : 6'h00;  // [R4] [R8]
  wire       clr_brk = rd_buf && arm_brk;  // [R12]
  wire       full_go = rx_full_flag && !clr1[ST1_FULL];
  wire       accept  = char_done && !full_go;
  wire       overrun = char_done && full_go;  // [R1]
  wire       brk_set = accept && rx_char.brk;

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      arm1    <= 6'h00;
      arm_brk <= 1'b0;
    end
    else if (rd_buf)
    begin
      arm1    <= 6'h00;
      arm_brk <= 1'b0;
    end
    else
    begin
      if (rd_stat1)
        arm1 <= rx_status_one[5:0];  // [R4]
      if (rd_stat2)
        arm_brk <= break_seen_flag;
    end
  end

  // Set wins over a clear landing in the same cycle
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rx_full_flag       <= 1'b0;
      idle_flag          <= 1'b0;
      overrun_flag       <= 1'b0;  // [R9]
      noise_flag         <= 1'b0;
      framing_fault_flag <= 1'b0;
      parity_fault_flag  <= 1'b0;
      break_seen_flag    <= 1'b0;
    end
    else
    begin
      rx_full_flag       <= accept || (rx_full_flag && !clr1[ST1_FULL]);  // [R11]
      idle_flag          <= (idle_hit && idle_ok) || (idle_flag && !clr1[ST1_IDLE]);
      overrun_flag       <= overrun || (overrun_flag && !clr1[ST1_OVERRUN]);  // [R1] [R4]
      noise_flag         <= (accept && rx_char.noise) || (noise_flag && !clr1[ST1_NOISE]);  // [R5]
      framing_fault_flag <= (accept && rx_char.framing) || (framing_fault_flag && !clr1[ST1_FRAMING]);  // [R6] [R8]
      parity_fault_flag  <= (accept && rx_char.parity_bad) || (parity_fault_flag && !clr1[ST1_PARITY]);  // [R7] [R8]
      break_seen_flag    <= brk_set || (break_seen_flag && !clr_brk);  // [R11] [R12]
    end
  end

  // Activity, break re-arm and idle qualification
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rx_active_flag <= 1'b0;
      break_armed    <= 1'b1;
      idle_ok        <= 1'b0;
    end
    else
    begin
      if (start_low && rx_on)
        rx_active_flag <= 1'b1;  // [R14]
      else if (false_st || idle_hit || !rx_on)
        rx_active_flag <= 1'b0;  // [R15]
      if (rt_tick && line)
        break_armed <= 1'b1;  // [R13]
      else if (brk_set)
        break_armed <= 1'b0;
      if (accept)
        idle_ok <= 1'b1;
      else if (idle_hit)
        idle_ok <= 1'b0;
    end
  end

  // Buffer keeps its old byte on overrun and has no reset
  always_ff @(posedge core_clk)
  begin
    if (accept)
      serial_data_buffer <= rx_char.data;  // [R2] [R16]
  end

  // Ninth bit follows the accepted character and is forced low by a break
  always_ff @(posedge core_clk)
  begin
    if (accept)
      rx_ninth_bit <= rx_char.ninth && !rx_char.brk;  // [R11]
  end

  // ********************************************************
  // Error request
  // ********************************************************
  // Break and activity flags are left out of the request on purpose [R12] [R14]
  wire err_any = (overrun_flag && ctrl3[C3_OVERRUN_EN])              // [R3]
              || (noise_flag && ctrl3[C3_NOISE_EN])                  // [R5]
              || (framing_fault_flag && ctrl3[C3_FRAMING_EN])        // [R6]
              || (parity_fault_flag && ctrl3[C3_PARITY_EN]);         // [R7]

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      serial_error_irq <= 1'b0;
    else
      serial_error_irq <= err_any;  // [R22]
  end

endmodule

`default_nettype wire

// ==== design/serial_rx_pkg.sv ====
// Constants, field layout and carrier types of the serial receive block.
// Assumes one 125 MHz core clock and an 8-bit register port.
package serial_rx_pkg;

  // ********************************************************
  // Register map
  // ********************************************************
  localparam int          ADDR_W          = 8;
  localparam int          DATA_W          = 8;
  localparam logic [7:0]  CTRL3_ADDR      = 8'h15;
  localparam logic [7:0]  STAT1_ADDR      = 8'h16;
  localparam logic [7:0]  STAT2_ADDR      = 8'h17;
  localparam logic [7:0]  DATA_ADDR       = 8'h18;
  localparam logic [7:0]  RATE_ADDR       = 8'h19;
  localparam logic [7:0]  FORMAT_ADDR     = 8'h1a;

  // Status one bit positions
  localparam int          ST1_FULL        = 5;
  localparam int          ST1_IDLE        = 4;
  localparam int          ST1_OVERRUN     = 3;
  localparam int          ST1_NOISE       = 2;
  localparam int          ST1_FRAMING     = 1;
  localparam int          ST1_PARITY      = 0;
  // Status two bit positions
  localparam int          ST2_BREAK       = 1;
  localparam int          ST2_ACTIVE      = 0;
  // Control three bit positions
  localparam int          C3_RX_NINTH     = 7;
  localparam int          C3_TX_NINTH     = 6;
  localparam int          C3_OVERRUN_EN   = 3;
  localparam int          C3_NOISE_EN     = 2;
  localparam int          C3_FRAMING_EN   = 1;
  localparam int          C3_PARITY_EN    = 0;
  // Rate register fields
  localparam int          RATE_PRE_LSB    = 4;
  localparam int          RATE_DIV_LSB    = 0;
  // Format register bit positions
  localparam int          FMT_NINE        = 0;
  localparam int          FMT_PAR_ON      = 1;
  localparam int          FMT_PAR_ODD     = 2;
  localparam int          FMT_RX_ON       = 3;

  // Reset values
  localparam logic [1:0]  PRESCALE_RST    = 2'h0;
  localparam logic [2:0]  RATE_DIV_RST    = 3'h0;
  localparam logic [3:0]  FORMAT_RST      = 4'h0;
  localparam logic [4:0]  CTRL3_RST       = 5'h00;

  // ********************************************************
  // Timing
  // ********************************************************
  localparam int          BIT_CLK_DIV     = 64;   // Clocks per bit before PD and BD
  localparam int          RT_PER_BIT      = 16;   // Receiver samples per bit
  localparam int          CLK_PER_RT      = BIT_CLK_DIV / RT_PER_BIT;
  localparam int          RT_CNT_W        = 13;
  localparam int          IDLE_BITS       = 10;
  localparam logic [7:0]  IDLE_RT         = 8'(IDLE_BITS * RT_PER_BIT);
  localparam logic [3:0]  SAMPLE_FIRST    = 4'h8;
  localparam logic [3:0]  SAMPLE_LAST     = 4'ha;
  localparam logic [3:0]  PHASE_LAST      = 4'hf;
  localparam logic [3:0]  BITS_EIGHT      = 4'h8;

  // ********************************************************
  // Carrier types
  // ********************************************************
  typedef struct packed {
    logic [7:0] data;
    logic       ninth;
    logic       noise;
    logic       parity_bad;
    logic       framing;
    logic       brk;
  } rx_char_s;

  typedef enum {
    st_hunt,
    st_start,
    st_data,
    st_stop
  } rx_state_e;

endpackage

// ==== tb/async_serial_rx_status_and_baud_bench.sv ====
// Self-checking bench for the serial receive status and rate block.
// Assumes the bound checker and the line model beside the design.
`timescale 1ns/1ps
`default_nettype none

`define CHK(got, exp) \
  begin \
    tests_run++; \
    if ((got) !== (exp)) \
    begin \
      n_errors++; \
      $display("Error at %0t: got %h expected %h", $time, got, exp); \
    end \
  end

module async_serial_rx_status_and_baud_bench
  import serial_rx_pkg::*;
;
  logic       core_clk;
  logic       rstn;
  logic [7:0] addr;
  logic [7:0] wr_data;
  logic       wr_en;
  logic       rd_en;
  logic [7:0] rd_data;
  logic       serial_input_pin;
  logic       serial_error_irq;
  logic [7:0] tx_data;
  logic       tx_ninth;
  logic       tx_write;
  logic       baud_tick;
  int         n_errors;
  int         tests_run;
  int         n;
  int         pd[4] = '{1, 3, 4, 13};

  serial_rx dut_u (
    .core_clk         (core_clk),
    .rstn             (rstn),
    .addr             (addr),
    .wr_data          (wr_data),
    .wr_en            (wr_en),
    .rd_en            (rd_en),
    .rd_data          (rd_data),
    .serial_input_pin (serial_input_pin),
    .serial_error_irq (serial_error_irq),
    .tx_data          (tx_data),
    .tx_ninth         (tx_ninth),
    .tx_write         (tx_write),
    .baud_tick        (baud_tick)
  );

  serial_line_model model_u (
    .core_clk (core_clk),
    .line     (serial_input_pin)
  );

  // 125 MHz core clock
  always #4 core_clk = ~core_clk;

  // ************************
  // Bus and check tasks
  // ************************
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge core_clk);
    wr_en <= 1'b0;
  endtask

  // Answer stands only in the cycle after the strobe
  task automatic exp_rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge core_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge core_clk);
    rd_en <= 1'b0;
    #1;
    `CHK(rd_data & m, e)
  endtask

  // Flags land a few clocks after the stop sample, well before this returns
  task automatic frame(input logic [7:0] d, input logic stop, input bit g);
    model_u.send(d, stop, g);
    repeat (8) @(posedge core_clk);
  endtask

  task automatic tick_gap(output int t);
    int k;
    k = 0;
    #1;
    while (baud_tick !== 1'b1 && k < 4000)
    begin
      @(posedge core_clk);
      #1;
      k++;
    end
    t = 0;
    do
    begin
      @(posedge core_clk);
      #1;
      t++;
    end
    while (baud_tick !== 1'b1 && t < 4000);
    if (k == 4000 || t == 4000)
    begin
      n_errors++;
      conclude();
    end
  endtask

  task automatic conclude;
    $display("Counts: %0d compares, %0d mismatches", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Guard against a hang anywhere in the sequence
  initial
  begin
    repeat (100000) @(posedge core_clk);
    n_errors++;
    conclude();
  end

  // ************************
  // Main sequence
  // ************************
  initial
  begin
    core_clk = 1'b0;
    rstn = 1'b0;
    addr = 8'h00;
    wr_data = 8'h00;
    wr_en = 1'b0;
    rd_en = 1'b0;
    n_errors = 0;
    tests_run = 0;
    repeat (4) @(posedge core_clk);
    rstn <= 1'b1;
    exp_rd(STAT1_ADDR, 8'hff, 8'h00);
    wr(STAT2_ADDR, 8'hff);
    exp_rd(STAT2_ADDR, 8'hff, 8'h00);
    $display("Test reset done");
    // Every field code reads back; then bit time for each prescale code
    for (int i = 0; i < 8; i++)
    begin
      wr(RATE_ADDR, {2'h0, i[1:0], 1'b0, i[2:0]});
      exp_rd(RATE_ADDR, 8'hff, {2'h0, i[1:0], 1'b0, i[2:0]});
    end
    for (int p = 0; p < 4; p++)
    begin
      wr(RATE_ADDR, {2'h0, p[1:0], 4'h1});
      tick_gap(n);
      tick_gap(n);
      `CHK(n, 64 * pd[p] * 2)
    end
    wr(RATE_ADDR, 8'h00);
    $display("Test rate done");
    wr(FORMAT_ADDR, 8'h08);
    wr(CTRL3_ADDR, 8'h0f);
    // Overrun lands between the status read and the data read
    frame(8'h5a, 1'b1, 1'b0);
    exp_rd(STAT1_ADDR, 8'hef, 8'h20);
    frame(8'hc3, 1'b1, 1'b0);
    `CHK(serial_error_irq, 1'b1)
    exp_rd(DATA_ADDR, 8'hff, 8'h5a);
    exp_rd(STAT1_ADDR, 8'hcf, 8'h08);
    exp_rd(DATA_ADDR, 8'hff, 8'h5a);
    exp_rd(STAT1_ADDR, 8'hcf, 8'h00);
    `CHK(serial_error_irq, 1'b0)
    $display("Test overrun done");
    // Noise, framing and parity, each set then cleared
    frame(8'h96, 1'b1, 1'b1);
    exp_rd(STAT1_ADDR, 8'hcf, 8'h04);
    `CHK(serial_error_irq, 1'b1)
    exp_rd(DATA_ADDR, 8'hff, 8'h96);
    exp_rd(STAT1_ADDR, 8'hcf, 8'h00);
    frame(8'h3c, 1'b0, 1'b0);
    exp_rd(STAT1_ADDR, 8'hcf, 8'h02);
    `CHK(serial_error_irq, 1'b1)
    exp_rd(DATA_ADDR, 8'hff, 8'h3c);
    exp_rd(STAT1_ADDR, 8'hcf, 8'h00);
    wr(FORMAT_ADDR, 8'h0a);
    frame(8'h01, 1'b1, 1'b0);
    exp_rd(STAT1_ADDR, 8'hcf, 8'h01);
    `CHK(serial_error_irq, 1'b1)
    exp_rd(DATA_ADDR, 8'hff, 8'h01);
    exp_rd(STAT1_ADDR, 8'hcf, 8'h00);
    wr(FORMAT_ADDR, 8'h0e);
    frame(8'h01, 1'b1, 1'b0);
    exp_rd(STAT1_ADDR, 8'hcf, 8'h00);
    exp_rd(DATA_ADDR, 8'hff, 8'h01);
    wr(FORMAT_ADDR, 8'h08);
    $display("Test errors done");
    // Break twice with ones between; framing request masked off
    wr(CTRL3_ADDR, 8'h0d);
    for (int b = 0; b < 2; b++)
    begin
      frame(8'h00, 1'b0, 1'b0);
      exp_rd(STAT1_ADDR, 8'hef, 8'h22);
      exp_rd(STAT2_ADDR, 8'h02, 8'h02);
      `CHK(serial_error_irq, 1'b0)
      exp_rd(DATA_ADDR, 8'hff, 8'h00);
      exp_rd(STAT2_ADDR, 8'h02, 8'h00);
      exp_rd(STAT1_ADDR, 8'hcf, 8'h00);
    end
    $display("Test break done");
    // Activity flag during a frame, gone once the line has idled
    fork
      frame(8'h55, 1'b1, 1'b0);
      begin
        repeat (100) @(posedge core_clk);
        exp_rd(STAT2_ADDR, 8'h01, 8'h01);
      end
    join
    repeat (800) @(posedge core_clk);
    exp_rd(STAT2_ADDR, 8'h01, 8'h00);
    exp_rd(STAT1_ADDR, 8'h10, 8'h10);
    exp_rd(DATA_ADDR, 8'hff, 8'h55);
    $display("Test activity done");
    wr(DATA_ADDR, 8'ha5);
    #1;
    `CHK(tx_data, 8'ha5)
    wr(CTRL3_ADDR, 8'h40);
    #1;
    `CHK(tx_ninth, 1'b1)
    $display("Test transmit done");
    conclude();
  end
endmodule

`default_nettype wire

// ==== tb/serial_line_model.sv ====
// Remote serial sender driving the receive line.
// Assumes rate fields at zero: 64 core clocks per bit.
`timescale 1ns/1ps
`default_nettype none

module serial_line_model (
  input  wire logic core_clk,
  output logic      line
);
  // Line idles high like any async sender
  initial line = 1'b1;

  // ************************
  // Frame sender
  // ************************
  // Start, eight data bits LSB first, stop; optional short glitch mid bit 3
  task automatic send(input logic [7:0] d, input logic stop, input bit glitch);
    logic [9:0] f;
    f = {stop, d, 1'b0};
    for (int b = 0; b < 10; b++)
      for (int c = 0; c < 64; c++)
      begin
        @(posedge core_clk);
        line <= f[b] ^ (glitch && b == 4 && c >= 34 && c < 38);
      end
    @(posedge core_clk);
    line <= 1'b1; // Ones after every frame re-arm break detection
  endtask
endmodule

`default_nettype wire

// ==== tb/serial_rx_sva.sv ====
// Port checker for the serial receive block.
// Assumes it is bound to serial_rx and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none

module serial_rx_sva
  import serial_rx_pkg::*;
(
  input wire logic              core_clk,
  input wire logic              rstn,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wr_data,
  input wire logic              wr_en,
  input wire logic              rd_en,
  input wire logic [DATA_W-1:0] rd_data,
  input wire logic              serial_input_pin,
  input wire logic              serial_error_irq,
  input wire logic [DATA_W-1:0] tx_data,
  input wire logic              tx_ninth,
  input wire logic              tx_write,
  input wire logic              baud_tick
);
  // ************************
  // Properties
  // ************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  // Bus steps used by the multi-cycle properties
  sequence s_data_wr;
    wr_en && addr == DATA_ADDR;
  endsequence
  sequence s_rate_rb;
    wr_en && addr == RATE_ADDR ##2 rd_en && addr == RATE_ADDR;
  endsequence

  AST_TX_PULSE: assert property (s_data_wr |=> tx_write && tx_data == $past(wr_data))
    else $error("Transmit byte not handed on");
  AST_TX_QUIET: assert property (!(wr_en && addr == DATA_ADDR) |=> !tx_write && $stable(tx_data))
    else $error("Transmit side moved without a data write");
  AST_RD_IDLE: assert property (!rd_en |=> rd_data == 8'h00)
    else $error("Read data not zero outside a read answer");
  AST_ST2_ZERO: assert property (rd_en && addr == STAT2_ADDR |=> rd_data[7:2] == 6'h00)
    else $error("Status two upper bits not zero");
  AST_RATE_RB: assert property (s_rate_rb |=> (rd_data & 8'h37) == ($past(wr_data, 3) & 8'h37))
    else $error("Rate fields do not read back");
  // Two edges: enables land on the first, the registered request follows
  AST_IRQ_MASK: assert property (wr_en && addr == CTRL3_ADDR && wr_data[3:0] == 4'h0 |-> ##2 !serial_error_irq)
    else $error("Error request high with all enables off");
  // Shortest bit is 64 clocks, so ticks never crowd
  AST_TICK_GAP: assert property (baud_tick |=> !baud_tick [*8])
    else $error("Bit ticks too close");
  AST_TX_NINTH: assert property (wr_en && addr == CTRL3_ADDR |=> tx_ninth == $past(wr_data[C3_TX_NINTH]))
    else $error("Transmit ninth bit not taken");
endmodule

bind serial_rx serial_rx_sva sva_u (
  .core_clk         (core_clk),
  .rstn             (rstn),
  .addr             (addr),
  .wr_data          (wr_data),
  .wr_en            (wr_en),
  .rd_en            (rd_en),
  .rd_data          (rd_data),
  .serial_input_pin (serial_input_pin),
  .serial_error_irq (serial_error_irq),
  .tx_data          (tx_data),
  .tx_ninth         (tx_ninth),
  .tx_write         (tx_write),
  .baud_tick        (baud_tick)
);

`default_nettype wire
